// File: rtl/imbu_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module imbu_fifo #(
    parameter int W = imbu_pkg::MSG_W, // Entry width.
    parameter int D = imbu_pkg::FIFO_DEPTH // Entry count.
) (
    input wire logic clk, // Board clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    imbu_fifo_if.store f // Push and pop side.
);
    import imbu_pkg::*;
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } imbu_fifo_st_t;
    imbu_fifo_st_t s;
    imbu_fifo_st_t next_s;
    logic do_push;
    logic do_pop;

    assign f.full = (s.cnt == CW'(D));
    assign f.empty = (s.cnt == '0);
    assign f.rdata = s.mem[s.rp];
    assign do_push = f.push && !f.full;
    assign do_pop = f.pop && !f.empty;

    always_comb begin
        next_s = s;
        if (do_push) begin
            next_s.mem[s.wp] = f.wdata;
            next_s.wp = (s.wp == AW'(D - 1)) ? '0 : s.wp + 1'b1;
        end
        if (do_pop) begin
            next_s.rp = (s.rp == AW'(D - 1)) ? '0 : s.rp + 1'b1;
        end
        if (do_push && !do_pop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (do_pop && !do_push) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_fifo_full_hold;
        f.full && f.push && !f.pop |=> f.full && $stable(s.wp);
    endproperty
    a_fifo_full_hold: assert property (p_fifo_full_hold) // RULE6
        else $error("push into a full queue changed it");

    property p_fifo_depth;
        (s.cnt == CW'(D - 1)) && f.push && !f.pop |=> f.full;
    endproperty
    a_fifo_depth: assert property (p_fifo_depth) // RULE6
        else $error("queue not full after last free entry filled");
endmodule
`default_nettype wire

// File: rtl/imbu_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface imbu_fifo_if #(parameter int W = 8);
    logic push;
    logic pop;
    logic full;
    logic empty;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    modport store(input push, input pop, input wdata,
        output full, output empty, output rdata);
    modport user(output push, output pop, output wdata,
        input full, input empty, input rdata);
endinterface
`default_nettype wire

// File: rtl/imbu_pkg.sv
package imbu_pkg;
    localparam int N_VME = 7;
    localparam int N_MBX = 8;
    localparam int N_LOC = 23;
    localparam int N_SRC = 42;
    localparam int SRC_ACF = 0;
    localparam int SRC_SYF = 1;
    localparam int SRC_VME = 2;
    localparam int SRC_MBX = 9;
    localparam int SRC_BC0 = 17;
    localparam int SRC_BC1 = 18;
    localparam int SRC_LOC = 19;
    localparam int BC_TARGETS = 20;
    localparam int FIFO_DEPTH = 8;
    localparam int MSG_W = 8;
    localparam int SLOT_W = 5;
    localparam int ST_W = 3;
    localparam int ST_OVF0 = 0;
    localparam int ST_OVF1 = 1;
    localparam int ST_SPUR = 2;
    typedef logic [7:0] imbu_addr_t;
    typedef logic [7:0] imbu_data_t;
    localparam imbu_addr_t A_BASE = 8'h00;
    localparam imbu_addr_t A_STAT = 8'h01;
    localparam imbu_addr_t A_MASK = 8'h02;
    localparam imbu_addr_t A_MBX = 8'h03;
    localparam imbu_addr_t A_BC0 = 8'h04;
    localparam imbu_addr_t A_BC1 = 8'h05;
    localparam imbu_addr_t A_BCST = 8'h06;
    localparam imbu_addr_t A_SLOT = 8'h07;
    localparam imbu_addr_t A_LVL = 8'h40;
    localparam imbu_data_t RST_BASE = 8'h40;
    localparam imbu_data_t SPUR_VEC = 8'h18;
    localparam logic [2:0] RST_LVL = 3'h0;
    localparam logic [ST_W-1:0] RST_MASK = 3'h0;
endpackage

// File: rtl/imbu_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE1] Eight mailboxes; a write to one raises a local interrupt request.
// [RULE2] Each mailbox has its own level and returns its own vector.
// [RULE3] Locked read-modify-write on a mailbox is indivisible; clears wait.
// [RULE4] Sender writes once; the target field selects among 20 boards.
// [RULE5] Targeted boards accept in the same cycle and request an interrupt.
// [RULE6] Broadcast channel zero queues 8-bit messages eight deep.
// [RULE7] Broadcast channel one holds a single 8-bit message.
// [RULE8] Local, internal and seven bus requests merge into one request.
// [RULE9] Every source has its own programmable level, 1 to 7.
// [RULE10] Acknowledge yields own vector or a local or bus vector fetch.
// [RULE11] Power-fail and system-fail are sources too; 42 sources in all.
// [RULE12] Own vectors are base vector plus a fixed per-source increment.
// [RULE13] Equal levels resolve by fixed order; lowest source index wins.
module imbu_top #(
    parameter int FIFO_D = imbu_pkg::FIFO_DEPTH // Channel zero depth.
) (
    input wire logic clk, // Board clock, 100 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire imbu_pkg::imbu_addr_t reg_addr, // Register address.
    input wire imbu_pkg::imbu_data_t reg_wdata, // Register write data.
    input wire logic reg_wr, // Register write strobe.
    input wire logic reg_rd, // Register read strobe.
    output imbu_pkg::imbu_data_t reg_rdata, // Read data, next cycle.
    input wire logic vme_mbx_wr, // Bus write to a mailbox.
    input wire logic vme_mbx_rd, // Bus read of a mailbox.
    input wire logic vme_lock, // Bus read-modify-write in progress.
    input wire logic [2:0] vme_mbx_idx, // Mailbox number.
    output logic [7:0] vme_mbx_rdata, // Mailbox flag read back.
    input wire logic bc_wr, // Broadcast write seen on the bus.
    input wire logic bc_chan, // Broadcast channel.
    input wire logic [19:0] bc_target, // Targeted board field.
    input wire logic [7:0] bc_data, // Broadcast message.
    input wire logic [4:0] slot_id_pin, // Board slot strap.
    input wire logic [6:0] vme_irq_b, // Bus request lines 1..7.
    input wire logic acfail_b, // Bus power-fail, active low.
    input wire logic sysfail_b, // Bus system-fail, active low.
    input wire logic [imbu_pkg::N_LOC-1:0] loc_irq, // Local requests.
    input wire logic cpu_iack, // Processor acknowledge pulse.
    input wire logic [2:0] cpu_iack_lvl, // Level acknowledged.
    output logic [2:0] cpu_ipl, // Highest pending level.
    output logic vec_valid, // Own vector ready.
    output logic [7:0] vec, // Own vector.
    output logic fetch_local, // Fetch vector from local device.
    output logic [4:0] fetch_local_idx, // Which local device.
    output logic fetch_vme, // Fetch vector across the bus.
    output logic [2:0] fetch_vme_lvl, // Bus request line to acknowledge.
    output logic irq // Unmasked status event pending.
);
    import imbu_pkg::*;
    localparam int SYW = SLOT_W + N_LOC + N_VME + 2;
    localparam int SY_SLOT = N_LOC + N_VME + 2;
    localparam int SY_LOC = N_VME + 2;
    localparam logic [SYW-1:0] SY_RST = SYW'(9'h1ff);

    typedef struct packed {
        logic [1:0][SYW-1:0] sy;
        logic [N_MBX-1:0] mbx;
        logic [N_MBX-1:0] mbx_clr;
        logic [N_SRC-1:0][2:0] lvl;
        imbu_data_t base;
        logic [ST_W-1:0] stat;
        logic [ST_W-1:0] mask;
        imbu_data_t rdata;
        logic [7:0] mbx_rdata;
        logic bc1_full;
        logic [MSG_W-1:0] bc1;
        logic [2:0] ipl;
        logic vec_valid;
        logic [7:0] vec;
        logic fetch_local;
        logic [4:0] fetch_local_idx;
        logic fetch_vme;
        logic [2:0] fetch_vme_lvl;
    } imbu_st_t;

    imbu_st_t s;
    imbu_st_t next_s;
    logic [N_SRC-1:0] pend;
    logic [2:0] top_lvl;
    logic [5:0] win;
    logic win_ok;
    logic [SLOT_W-1:0] slot;
    logic hit;
    logic [N_MBX-1:0] mbx_set;
    logic [N_MBX-1:0] clr_now;
    logic [N_MBX-1:0] clr_all;
    logic [ST_W-1:0] set_st;
    logic [5:0] lvl_idx;
    logic lvl_hit;
    logic bc1_rd;
    logic [N_SRC-1:0] at_lvl;

    imbu_fifo_if #(.W(MSG_W)) bq ();

    imbu_fifo #(.W(MSG_W), .D(FIFO_D)) u_bc0 (
        .clk(clk),
        .rst_b(rst_b),
        .f(bq.store)
    );

    assign slot = s.sy[1][SY_SLOT +: SLOT_W];
    // A board whose slot lies outside the target field is never addressed.
    assign hit = bc_wr && (slot < SLOT_W'(BC_TARGETS)) && bc_target[slot]; // RULE4
    assign bq.push = hit && !bc_chan; // RULE5
    assign bq.wdata = bc_data; // RULE6
    assign bq.pop = reg_rd && (reg_addr == A_BC0) && !bq.empty;
    assign bc1_rd = reg_rd && (reg_addr == A_BC1);
    assign lvl_idx = 6'(reg_addr - A_LVL);
    assign lvl_hit = (reg_addr >= A_LVL) && (reg_addr < A_LVL + 8'(N_SRC));

    // Pending sources that sit at the level being acknowledged.
    for (genvar g = 0; g < N_SRC; g++) begin : g_at
        assign at_lvl[g] = pend[g] && (s.lvl[g] == cpu_iack_lvl);
    end

    // Pending sources and the level presented to the processor.
    always_comb begin
        pend = '0;
        pend[SRC_ACF] = !s.sy[1][0]; // RULE11
        pend[SRC_SYF] = !s.sy[1][1]; // RULE11
        pend[SRC_VME +: N_VME] = ~s.sy[1][2 +: N_VME]; // RULE8
        pend[SRC_MBX +: N_MBX] = s.mbx; // RULE1
        pend[SRC_BC0] = !bq.empty; // RULE5
        pend[SRC_BC1] = s.bc1_full; // RULE5
        pend[SRC_LOC +: N_LOC] = s.sy[1][SY_LOC +: N_LOC]; // RULE8
        top_lvl = '0;
        win = '0;
        win_ok = 1'b0;
        // Walking downward leaves the lowest index as winner.
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (pend[i] && (s.lvl[i] > top_lvl)) begin
                top_lvl = s.lvl[i]; // RULE9
            end
            if (pend[i] && (cpu_iack_lvl != 3'h0)
                && (s.lvl[i] == cpu_iack_lvl)) begin
                win = 6'(i); // RULE13
                win_ok = 1'b1;
            end
        end
    end

    always_comb begin
        next_s = s;
        set_st = '0;
        clr_now = '0;
        mbx_set = '0;
        clr_all = '0;
        next_s.sy[0] = {slot_id_pin, loc_irq, vme_irq_b, sysfail_b, acfail_b};
        next_s.sy[1] = s.sy[0];
        next_s.vec_valid = 1'b0;
        next_s.fetch_local = 1'b0;
        next_s.fetch_vme = 1'b0;
        next_s.ipl = top_lvl; // RULE8
        if (reg_wr) begin
            if (reg_addr == A_BASE) begin
                next_s.base = reg_wdata; // RULE12
            end else if (reg_addr == A_STAT) begin
                next_s.stat = s.stat & ~reg_wdata[ST_W-1:0];
            end else if (reg_addr == A_MASK) begin
                next_s.mask = reg_wdata[ST_W-1:0];
            end else if (reg_addr == A_MBX) begin
                clr_now = reg_wdata;
            end else if (lvl_hit) begin
                next_s.lvl[lvl_idx] = reg_wdata[2:0]; // RULE9
            end
        end
        next_s.rdata = '0;
        if (reg_rd) begin
            if (reg_addr == A_BASE) begin
                next_s.rdata = s.base;
            end else if (reg_addr == A_STAT) begin
                next_s.rdata = 8'(s.stat);
            end else if (reg_addr == A_MASK) begin
                next_s.rdata = 8'(s.mask);
            end else if (reg_addr == A_MBX) begin
                next_s.rdata = s.mbx;
            end else if (reg_addr == A_BC0) begin
                next_s.rdata = bq.empty ? 8'h00 : bq.rdata; // RULE6
            end else if (reg_addr == A_BC1) begin
                next_s.rdata = s.bc1; // RULE7
                next_s.bc1_full = 1'b0;
            end else if (reg_addr == A_BCST) begin
                next_s.rdata = {5'h00, s.bc1_full, bq.full, bq.empty};
            end else if (reg_addr == A_SLOT) begin
                next_s.rdata = 8'(slot);
            end else if (lvl_hit) begin
                next_s.rdata = 8'(s.lvl[lvl_idx]);
            end
        end
        if (cpu_iack) begin
            if (!win_ok) begin
                set_st[ST_SPUR] = 1'b1;
                next_s.vec_valid = 1'b1;
                next_s.vec = SPUR_VEC;
            end else if ((win >= 6'(SRC_VME)) && (win < 6'(SRC_MBX))) begin
                next_s.fetch_vme = 1'b1; // RULE10
                next_s.fetch_vme_lvl = 3'(win - 6'(SRC_VME - 1));
            end else if (win >= 6'(SRC_LOC)) begin
                next_s.fetch_local = 1'b1; // RULE10
                next_s.fetch_local_idx = 5'(win - 6'(SRC_LOC));
            end else begin
                next_s.vec_valid = 1'b1;
                next_s.vec = s.base + 8'(win); // RULE12
                if ((win >= 6'(SRC_MBX)) && (win < 6'(SRC_BC0))) begin
                    clr_now[3'(win - 6'(SRC_MBX))] = 1'b1; // RULE2
                end
            end
        end
        if (hit && !bc_chan && bq.full) begin
            set_st[ST_OVF0] = 1'b1;
        end
        if (hit && bc_chan) begin
            // The newest message replaces an unread one.
            if (s.bc1_full && !bc1_rd) begin
                set_st[ST_OVF1] = 1'b1;
            end
            next_s.bc1 = bc_data; // RULE7
            next_s.bc1_full = 1'b1; // RULE5
        end
        if (vme_mbx_wr) begin
            mbx_set[vme_mbx_idx] = 1'b1; // RULE1
        end
        if (vme_mbx_rd) begin
            next_s.mbx_rdata = {7'h00, s.mbx[vme_mbx_idx]}; // RULE3
        end
        // Local clears are held back while a locked cycle is in flight.
        clr_all = s.mbx_clr | clr_now;
        if (vme_lock) begin
            next_s.mbx_clr = clr_all & ~mbx_set; // RULE3
        end else begin
            next_s.mbx = s.mbx & ~clr_all;
            next_s.mbx_clr = '0;
        end
        next_s.mbx = next_s.mbx | mbx_set; // RULE1
        next_s.stat = next_s.stat | set_st;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.sy <= {SY_RST, SY_RST};
            s.base <= RST_BASE;
            s.mask <= RST_MASK;
            s.lvl <= {N_SRC{RST_LVL}};
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign vme_mbx_rdata = s.mbx_rdata;
    assign cpu_ipl = s.ipl;
    assign vec_valid = s.vec_valid;
    assign vec = s.vec;
    assign fetch_local = s.fetch_local;
    assign fetch_local_idx = s.fetch_local_idx;
    assign fetch_vme = s.fetch_vme;
    assign fetch_vme_lvl = s.fetch_vme_lvl;
    assign irq = |(s.stat & s.mask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_iack_mbx;
        cpu_iack && win_ok && (win >= 6'(SRC_MBX)) && (win < 6'(SRC_BC0));
    endsequence
    sequence s_bc1_hit;
        hit && bc_chan;
    endsequence

    property p_mbx_set;
        vme_mbx_wr |=> s.mbx[$past(vme_mbx_idx)];
    endproperty
    a_mbx_set: assert property (p_mbx_set) // RULE1
        else $error("mailbox write did not set its flag");

    property p_mbx_vec;
        s_iack_mbx |=> vec_valid && (vec == $past(s.base) + 8'($past(win)));
    endproperty
    a_mbx_vec: assert property (p_mbx_vec) // RULE2
        else $error("mailbox vector wrong");

    property p_lock;
        vme_lock |=> ((s.mbx & $past(s.mbx)) == $past(s.mbx));
    endproperty
    a_lock: assert property (p_lock) // RULE3
        else $error("mailbox cleared inside a locked cycle");

    property p_bc_miss;
        bc_wr && !hit |=> $stable(s.bc1);
    endproperty
    a_bc_miss: assert property (p_bc_miss) // RULE4
        else $error("untargeted broadcast was taken");

    property p_bc_ipl;
        s_bc1_hit ##1 (s.lvl[SRC_BC1] != 3'h0)
            |=> cpu_ipl >= $past(s.lvl[SRC_BC1]);
    endproperty
    a_bc_ipl: assert property (p_bc_ipl) // RULE5
        else $error("broadcast raised no request");

    property p_bc1_hold;
        s_bc1_hit |=> s.bc1_full && (s.bc1 == $past(bc_data));
    endproperty
    a_bc1_hold: assert property (p_bc1_hold) // RULE7
        else $error("channel one message not held");

    property p_vme_ipl;
        pend[SRC_VME] && (s.lvl[SRC_VME] != 3'h0)
            |=> cpu_ipl >= $past(s.lvl[SRC_VME]);
    endproperty
    a_vme_ipl: assert property (p_vme_ipl) // RULE9
        else $error("bus request level not presented");

    property p_acf_ipl;
        pend[SRC_ACF] && (s.lvl[SRC_ACF] != 3'h0)
            |=> cpu_ipl >= $past(s.lvl[SRC_ACF]);
    endproperty
    a_acf_ipl: assert property (p_acf_ipl) // RULE11
        else $error("power-fail level not presented");

    property p_fetch;
        cpu_iack && win_ok && (win >= 6'(SRC_LOC))
            |=> fetch_local && !vec_valid && !fetch_vme;
    endproperty
    a_fetch: assert property (p_fetch) // RULE10
        else $error("local vector fetch missing");

    property p_ack_one;
        cpu_iack |=> $onehot({vec_valid, fetch_local, fetch_vme});
    endproperty
    a_ack_one: assert property (p_ack_one) // RULE10
        else $error("acknowledge gave no single answer");

    property p_prio;
        cpu_iack && win_ok |-> at_lvl[win]
            && ((at_lvl & ((N_SRC'(1) << win) - 1'b1)) == '0);
    endproperty
    a_prio: assert property (p_prio) // RULE13
        else $error("lower index at same level was passed over");
endmodule
`default_nettype wire

// File: test/imbu_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module imbu_far_model (
    input wire logic clk, // Board clock.
    output var logic vme_mbx_wr, // Mailbox write.
    output var logic vme_mbx_rd, // Mailbox read.
    output var logic vme_lock, // Locked cycle.
    output var logic [2:0] vme_mbx_idx, // Mailbox number.
    input wire logic [7:0] vme_mbx_rdata, // Mailbox flag.
    output var logic bc_wr, // Broadcast write.
    output var logic bc_chan, // Broadcast channel.
    output var logic [19:0] bc_target, // Targeted boards.
    output var logic [7:0] bc_data, // Message.
    output var logic [6:0] vme_irq_b, // Bus request lines.
    output var logic acfail_b, // Power-fail.
    output var logic sysfail_b, // System-fail.
    output var logic [22:0] loc_irq // Local requests.
);
    initial begin
        {vme_mbx_wr, vme_mbx_rd, vme_lock, bc_wr, bc_chan} = 5'h00;
        vme_mbx_idx = 3'h0;
        bc_target = 20'h00000;
        bc_data = 8'h00;
        vme_irq_b = 7'h7f;
        {acfail_b, sysfail_b} = 2'h3;
        loc_irq = 23'h0;
    end
    // Released qualifiers show the inverse so stale values never match.
    task automatic mbx_wr(input logic [2:0] i);
        @(posedge clk);
        vme_mbx_wr <= 1'b1;
        vme_mbx_idx <= i;
        @(posedge clk);
        vme_mbx_wr <= 1'b0;
        vme_mbx_idx <= ~i;
    endtask
    task automatic mbx_rd(input logic [2:0] i, output logic [7:0] d);
        @(posedge clk);
        vme_mbx_rd <= 1'b1;
        vme_mbx_idx <= i;
        @(posedge clk);
        vme_mbx_rd <= 1'b0;
        vme_mbx_idx <= ~i;
        #1;
        d = vme_mbx_rdata;
    endtask
    task automatic lock(input logic v);
        @(posedge clk);
        vme_lock <= v;
    endtask
    task automatic bc_send(input logic c, input logic [19:0] t,
                           input logic [7:0] d);
        @(posedge clk);
        bc_wr <= 1'b1;
        bc_chan <= c;
        bc_target <= t;
        bc_data <= d;
        @(posedge clk);
        bc_wr <= 1'b0;
        bc_target <= ~t;
        bc_data <= ~d;
    endtask
    task automatic pins(input logic [6:0] vb, input logic af,
                        input logic sf, input logic [22:0] li);
        @(posedge clk);
        vme_irq_b <= vb;
        acfail_b <= af;
        sysfail_b <= sf;
        loc_irq <= li;
    endtask
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import imbu_pkg::*;
    logic clk, rst_b, reg_wr, reg_rd, cpu_iack, vec_valid, irq;
    logic fetch_local, fetch_vme, vme_mbx_wr, vme_mbx_rd, vme_lock;
    logic bc_wr, bc_chan, acfail_b, sysfail_b;
    imbu_addr_t reg_addr;
    imbu_data_t reg_wdata, reg_rdata;
    logic [7:0] vme_mbx_rdata, bc_data, vec, d;
    logic [2:0] vme_mbx_idx, cpu_iack_lvl, cpu_ipl, fetch_vme_lvl;
    logic [19:0] bc_target;
    logic [4:0] slot_id_pin, fetch_local_idx;
    logic [6:0] vme_irq_b;
    logic [N_LOC-1:0] loc_irq;
    int errors = 0;
    int samples_checked = 0;

    imbu_top #(.FIFO_D(FIFO_DEPTH)) imbu_top_i (.clk(clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vme_mbx_wr(vme_mbx_wr),
        .vme_mbx_rd(vme_mbx_rd), .vme_lock(vme_lock),
        .vme_mbx_idx(vme_mbx_idx), .vme_mbx_rdata(vme_mbx_rdata),
        .bc_wr(bc_wr), .bc_chan(bc_chan), .bc_target(bc_target),
        .bc_data(bc_data), .slot_id_pin(slot_id_pin),
        .vme_irq_b(vme_irq_b), .acfail_b(acfail_b), .sysfail_b(sysfail_b),
        .loc_irq(loc_irq), .cpu_iack(cpu_iack), .cpu_iack_lvl(cpu_iack_lvl),
        .cpu_ipl(cpu_ipl), .vec_valid(vec_valid), .vec(vec),
        .fetch_local(fetch_local), .fetch_local_idx(fetch_local_idx),
        .fetch_vme(fetch_vme), .fetch_vme_lvl(fetch_vme_lvl), .irq(irq));
    imbu_far_model imbu_far_model_i (.clk(clk), .vme_mbx_wr(vme_mbx_wr),
        .vme_mbx_rd(vme_mbx_rd), .vme_lock(vme_lock),
        .vme_mbx_idx(vme_mbx_idx), .vme_mbx_rdata(vme_mbx_rdata),
        .bc_wr(bc_wr), .bc_chan(bc_chan), .bc_target(bc_target),
        .bc_data(bc_data), .vme_irq_b(vme_irq_b), .acfail_b(acfail_b),
        .sysfail_b(sysfail_b), .loc_irq(loc_irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done;
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask
    task automatic wr(input imbu_addr_t a, input imbu_data_t v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input imbu_addr_t a, input imbu_data_t e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic lvl(input int i, input logic [2:0] l);
        wr(A_LVL + 8'(i), {5'h00, l});
    endtask
    task automatic wait_ipl(input logic [2:0] l);
        for (int n = 0; n < 20 && cpu_ipl !== l; n++)
            @(posedge clk);
        #1;
        chk({5'h00, cpu_ipl}, {5'h00, l});
    endtask
    // Kind is {fetch_vme, fetch_local, vec_valid}; value follows the kind.
    task automatic ack(input logic [2:0] l, input logic [2:0] k,
                       input logic [7:0] v);
        logic [7:0] got;
        @(posedge clk);
        cpu_iack <= 1'b1;
        cpu_iack_lvl <= l;
        @(posedge clk);
        cpu_iack <= 1'b0;
        #1;
        got = vec_valid ? vec : fetch_local ? {3'h0, fetch_local_idx} :
              {5'h00, fetch_vme_lvl};
        chk({5'h00, fetch_vme, fetch_local, vec_valid}, {5'h00, k});
        chk(got, v);
    endtask

    initial begin
        #100us;
        errors++;
        test_done();
    end

    initial begin
        {rst_b, reg_wr, reg_rd, cpu_iack} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        cpu_iack_lvl = 3'h0;
        slot_id_pin = 5'h06;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd(A_BASE, RST_BASE);
        rd(A_MASK, 8'h00);
        wr(A_BASE, 8'h80);
        rd(A_BASE, 8'h80);
        wr(8'h6a, 8'hff);
        rd(8'h6a, 8'h00);
        wr(A_MASK, 8'h07);
        rd(A_SLOT, 8'h06);
        // Two mailboxes at one level: the lower one is served first.
        for (int i = 0; i < N_MBX; i++)
            lvl(SRC_MBX + i, 3'h3);
        imbu_far_model_i.mbx_wr(3'h5);
        imbu_far_model_i.mbx_wr(3'h2);
        rd(A_MBX, 8'h24);
        wait_ipl(3'h3);
        ack(3'h3, 3'h1, 8'h8b);
        ack(3'h3, 3'h1, 8'h8e);
        rd(A_MBX, 8'h00);
        imbu_far_model_i.mbx_wr(3'h7);
        wr(A_MBX, 8'h80);
        rd(A_MBX, 8'h00);
        ack(3'h3, 3'h1, SPUR_VEC);
        chk({7'h00, irq}, 8'h01);
        rd(A_STAT, 8'h04);
        wr(A_STAT, 8'h04);
        chk({7'h00, irq}, 8'h00);
        // Acknowledge under a locked cycle must not clear the flag yet.
        imbu_far_model_i.mbx_wr(3'h1);
        imbu_far_model_i.lock(1'b1);
        wait_ipl(3'h3);
        ack(3'h3, 3'h1, 8'h8a);
        imbu_far_model_i.mbx_rd(3'h1, d);
        chk(d, 8'h01);
        imbu_far_model_i.lock(1'b0);
        imbu_far_model_i.mbx_rd(3'h1, d);
        chk(d, 8'h00);
        // Broadcast: untargeted write ignored, channel zero overflows.
        lvl(SRC_BC0, 3'h4);
        lvl(SRC_BC1, 3'h6);
        imbu_far_model_i.bc_send(1'b0, 20'h00001, 8'h11);
        rd(A_BCST, 8'h01);
        for (int i = 0; i < FIFO_DEPTH; i++)
            imbu_far_model_i.bc_send(1'b0, 20'h00040, 8'ha0 + 8'(i));
        imbu_far_model_i.bc_send(1'b0, 20'h00040, 8'hff);
        rd(A_BCST, 8'h02);
        rd(A_STAT, 8'h01);
        wait_ipl(3'h4);
        ack(3'h4, 3'h1, 8'h91);
        for (int i = 0; i < FIFO_DEPTH; i++)
            rd(A_BC0, 8'ha0 + 8'(i));
        rd(A_BCST, 8'h01);
        rd(A_BC0, 8'h00);
        imbu_far_model_i.bc_send(1'b1, 20'hfffff, 8'h55);
        imbu_far_model_i.bc_send(1'b1, 20'hfffff, 8'h66);
        rd(A_STAT, 8'h03);
        rd(A_BCST, 8'h05);
        wait_ipl(3'h6);
        ack(3'h6, 3'h1, 8'h92);
        rd(A_BC1, 8'h66);
        rd(A_BCST, 8'h01);
        wr(A_STAT, 8'h03);
        rd(A_STAT, 8'h00);
        // Bus line, local device and bus failure sources.
        lvl(SRC_VME, 3'h5);
        lvl(SRC_VME + 2, 3'h5);
        imbu_far_model_i.pins(7'h7a, 1'b1, 1'b1, 23'h0);
        wait_ipl(3'h5);
        ack(3'h5, 3'h4, 8'h01);
        imbu_far_model_i.pins(7'h7b, 1'b1, 1'b1, 23'h0);
        repeat (4) @(posedge clk);
        ack(3'h5, 3'h4, 8'h03);
        lvl(SRC_LOC + 4, 3'h2);
        imbu_far_model_i.pins(7'h7f, 1'b1, 1'b1, 23'h10);
        wait_ipl(3'h2);
        ack(3'h2, 3'h2, 8'h04);
        lvl(SRC_ACF, 3'h7);
        lvl(SRC_SYF, 3'h1);
        imbu_far_model_i.pins(7'h7f, 1'b0, 1'b0, 23'h0);
        wait_ipl(3'h7);
        ack(3'h7, 3'h1, 8'h80);
        ack(3'h1, 3'h1, 8'h81);
        test_done();
    end
endmodule
`default_nettype wire
